// [hdl/ata_ext_write_cmd_decode.v]
`include "ata_ext_write_map.vh"
`default_nettype none

module ata_ext_write_cmd_decode #(
  parameter WPS = `WORDS_PER_SECTOR
) (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        tf_wr,
  input  wire [2:0]  tf_addr,
  input  wire [7:0]  tf_wdata,
  input  wire [2:0]  tf_rd_addr,
  output reg  [7:0]  tf_rdata,
  input  wire        hob,
  input  wire        host_wvalid,
  input  wire [15:0] host_wdata,
  output wire        host_wready,
  output reg         media_wvalid,
  output reg  [15:0] media_wdata,
  input  wire        media_wready,
  input  wire        err_crc,
  input  wire        err_idnf,
  input  wire        err_abort,
  input  wire        cct_expired,
  output wire        busy,
  output wire        dma_mode,
  output wire        urgent,
  output wire        resume_stream_err,
  output wire [2:0]  stream_id,
  output wire [47:0] start_lba,
  output wire        flush_req,
  input  wire        flush_done,
  output reg         cmd_done,
  output reg         log_icrc,
  output reg         log_idnf,
  output reg         log_abrt,
  output reg         log_ccto
);

  localparam [2:0]  S_IDLE    = 3'b001;
  localparam [2:0]  S_XFER    = 3'b010;
  localparam [2:0]  S_FLUSH   = 3'b100;
  localparam integer LAST_WORD_I = WPS - 1;
  localparam [15:0]  LAST_WORD   = LAST_WORD_I[15:0];

  reg  [2:0]  state_r;
  reg  [7:0]  cmd_r;
  reg  [16:0] remaining_r;
  reg  [15:0] word_cnt_r;
  reg  [47:0] cur_lba_r;
  reg  [47:0] fail_lba_r;
  reg         fail_valid_r;
  reg         err_r;
  reg         se_r;
  reg  [7:0]  error_r;
  reg  [7:0]  dev_r;

  wire [7:0]  feat_cur;
  wire [7:0]  cnt_cur;
  wire [7:0]  cnt_prev;
  wire [7:0]  sn_cur;
  wire [7:0]  sn_prev;
  wire [7:0]  cl_cur;
  wire [7:0]  cl_prev;
  wire [7:0]  ch_cur;
  wire [7:0]  ch_prev;

  wire        idle      = state_r == S_IDLE;
  wire        in_xfer   = state_r == S_XFER;
  wire        tf_take   = tf_wr && idle;
  wire        cmd_take  = tf_take && tf_addr == `TF_COMMAND;
  wire        is_stream = cmd_r == `CMD_WRITE_STREAM;
  wire        wcont     = is_stream && feat_cur[`FEAT_WCONT];
  wire [15:0] count16   = {cnt_prev, cnt_cur};
  wire        word_take = host_wvalid && host_wready;
  wire        sec_done  = word_take && word_cnt_r == LAST_WORD;
  wire        last_sec  = remaining_r == 17'h0_0001;
  wire        any_err   = in_xfer && (err_crc || err_idnf || err_abort);
  wire        cct_stop  = is_stream && cct_expired && !idle;
  wire        err_stop  = any_err && !wcont;
  wire        logged    = log_icrc || log_idnf || log_abrt;

  // Taskfile byte pairs, written only while no command runs
  taskfile_pair u_feat (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .wr      (tf_take && tf_addr == `TF_FEATURE),
    .wdata   (tf_wdata),
    .cur     (feat_cur),
    .prev    ()
  );
  taskfile_pair u_cnt (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .wr      (tf_take && tf_addr == `TF_COUNT),
    .wdata   (tf_wdata),
    .cur     (cnt_cur),
    .prev    (cnt_prev)
  );
  taskfile_pair u_sn (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .wr      (tf_take && tf_addr == `TF_SECNUM),
    .wdata   (tf_wdata),
    .cur     (sn_cur),
    .prev    (sn_prev)
  );
  taskfile_pair u_cl (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .wr      (tf_take && tf_addr == `TF_CYLLO),
    .wdata   (tf_wdata),
    .cur     (cl_cur),
    .prev    (cl_prev)
  );
  taskfile_pair u_ch (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .wr      (tf_take && tf_addr == `TF_CYLHI),
    .wdata   (tf_wdata),
    .cur     (ch_cur),
    .prev    (ch_prev)
  );

  assign start_lba = {ch_prev, cl_prev, sn_prev, ch_cur, cl_cur, sn_cur};
  assign busy      = !idle;
  assign dma_mode  = !idle && is_stream;
  assign urgent    = !idle && is_stream && feat_cur[`FEAT_URGENT];
  assign resume_stream_err = !idle && is_stream && feat_cur[`FEAT_HSE];
  assign stream_id = feat_cur[`FEAT_SID_HI:`FEAT_SID_LO];
  assign flush_req = state_r == S_FLUSH;
  // One word per beat, stalled while the media side holds a word
  assign host_wready = in_xfer && (!media_wvalid || media_wready);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dev_r <= 8'h00;
    end else if (tf_take && tf_addr == `TF_DEVICE) begin
      dev_r <= tf_wdata;
    end
  end

  // Word forwarding toward the media path
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      media_wvalid <= 1'b0;
      media_wdata  <= 16'h0000;
    end else if (word_take) begin
      media_wvalid <= 1'b1;
      media_wdata  <= host_wdata;
    end else if (media_wready) begin
      media_wvalid <= 1'b0;
    end
  end

  // Command sequencer
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r      <= S_IDLE;
      cmd_r        <= 8'h00;
      remaining_r  <= 17'h0_0000;
      word_cnt_r   <= 16'h0000;
      cur_lba_r    <= 48'h0000_0000_0000;
      fail_lba_r   <= 48'h0000_0000_0000;
      fail_valid_r <= 1'b0;
      err_r        <= 1'b0;
      se_r         <= 1'b0;
      error_r      <= `ERROR_RESET;
      cmd_done     <= 1'b0;
      log_icrc     <= 1'b0;
      log_idnf     <= 1'b0;
      log_abrt     <= 1'b0;
      log_ccto     <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (cmd_take) begin
            cmd_r        <= tf_wdata;
            word_cnt_r   <= 16'h0000;
            cur_lba_r    <= start_lba;
            fail_valid_r <= 1'b0;
            err_r        <= 1'b0;
            se_r         <= 1'b0;
            error_r      <= `ERROR_RESET;
            log_icrc     <= 1'b0;
            log_idnf     <= 1'b0;
            log_abrt     <= 1'b0;
            log_ccto     <= 1'b0;
            remaining_r  <= (count16 == 16'h0000) ? `COUNT_ZERO_LOAD
                                                  : {1'b0, count16};
            if (tf_wdata == `CMD_WRITE_EXT ||
                tf_wdata == `CMD_WRITE_STREAM) begin
              state_r <= S_XFER;
            end else begin
              err_r             <= 1'b1;
              error_r[`ER_ABT]  <= 1'b1;
              cmd_done          <= 1'b1;
            end
          end
        end
        S_XFER: begin
          if (cct_stop) begin
            state_r  <= S_IDLE;
            cmd_done <= 1'b1;
            if (wcont) begin
              se_r     <= 1'b1;
              log_ccto <= 1'b1;
            end else begin
              err_r             <= 1'b1;
              error_r[`ER_CCTO] <= 1'b1;
            end
          end else if (err_stop) begin
            state_r      <= S_IDLE;
            cmd_done     <= 1'b1;
            err_r        <= 1'b1;
            fail_lba_r   <= cur_lba_r;
            fail_valid_r <= 1'b1;
            error_r[`ER_CRC] <= is_stream && err_crc;
            error_r[`ER_IDN] <= err_idnf;
            error_r[`ER_ABT] <= err_abort || (!is_stream && err_crc);
          end else begin
            if (any_err) begin
              log_icrc <= log_icrc || err_crc;
              log_idnf <= log_idnf || err_idnf;
              log_abrt <= log_abrt || err_abort;
              if (!fail_valid_r) begin
                fail_lba_r   <= cur_lba_r;
                fail_valid_r <= 1'b1;
              end
            end
            if (word_take) begin
              word_cnt_r <= sec_done ? 16'h0000 : word_cnt_r + 16'h0001;
            end
            if (sec_done) begin
              cur_lba_r   <= cur_lba_r + 48'h0000_0000_0001;
              remaining_r <= remaining_r - 17'h0_0001;
              if (last_sec) begin
                if (is_stream && feat_cur[`FEAT_FLUSH]) begin
                  state_r <= S_FLUSH;
                end else begin
                  state_r  <= S_IDLE;
                  cmd_done <= 1'b1;
                  se_r     <= logged || any_err;
                end
              end
            end
          end
        end
        S_FLUSH: begin
          if (cct_stop) begin
            state_r  <= S_IDLE;
            cmd_done <= 1'b1;
            if (wcont) begin
              se_r     <= 1'b1;
              log_ccto <= 1'b1;
            end else begin
              err_r             <= 1'b1;
              error_r[`ER_CCTO] <= 1'b1;
            end
          end else if (flush_done) begin
            state_r  <= S_IDLE;
            cmd_done <= 1'b1;
            se_r     <= logged;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // Registered taskfile read path
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tf_rdata <= 8'h00;
    end else begin
      case (tf_rd_addr)
        `TF_ERROR:  tf_rdata <= error_r;
        `TF_COUNT:  tf_rdata <= hob ? cnt_prev : cnt_cur;
        `TF_SECNUM: tf_rdata <= fail_valid_r ?
                      (hob ? fail_lba_r[31:24] : fail_lba_r[7:0]) :
                      (hob ? sn_prev : sn_cur);
        `TF_CYLLO:  tf_rdata <= fail_valid_r ?
                      (hob ? fail_lba_r[39:32] : fail_lba_r[15:8]) :
                      (hob ? cl_prev : cl_cur);
        `TF_CYLHI:  tf_rdata <= fail_valid_r ?
                      (hob ? fail_lba_r[47:40] : fail_lba_r[23:16]) :
                      (hob ? ch_prev : ch_cur);
        `TF_DEVICE: tf_rdata <= dev_r;
        `TF_STATUS: tf_rdata <= {busy, 1'b1, se_r, 1'b0,
                                 in_xfer && !is_stream, 2'b00, err_r};
        default:    tf_rdata <= 8'h00;
      endcase
    end
  end

endmodule // ata_ext_write_cmd_decode

`default_nettype wire

// [hdl/ata_ext_write_map.vh]
`ifndef ATA_EXT_WRITE_MAP_VH
`define ATA_EXT_WRITE_MAP_VH

// Taskfile addresses, host write side
`define TF_FEATURE        3'h1
`define TF_COUNT          3'h2
`define TF_SECNUM         3'h3
`define TF_CYLLO          3'h4
`define TF_CYLHI          3'h5
`define TF_DEVICE         3'h6
`define TF_COMMAND        3'h7
// Taskfile addresses, host read side
`define TF_ERROR          3'h1
`define TF_STATUS         3'h7

// Command codes
`define CMD_WRITE_EXT     8'h34
`define CMD_WRITE_STREAM  8'h3A

// Feature byte fields
`define FEAT_URGENT       7
`define FEAT_WCONT        6
`define FEAT_FLUSH        5
`define FEAT_HSE          4
`define FEAT_SID_HI       2
`define FEAT_SID_LO       0

// Status bit positions
`define ST_BSY            7
`define ST_RDY            6
`define ST_SE             5
`define ST_DRQ            3
`define ST_ERR            0

// Error bit positions
`define ER_CRC            7
`define ER_IDN            4
`define ER_ABT            2
`define ER_CCTO           0

// Reset values and sizes
`define ERROR_RESET       8'h00
`define WORDS_PER_SECTOR  256
`define COUNT_ZERO_LOAD   17'h1_0000

`endif

// [hdl/taskfile_pair.v]
`default_nettype none

// One taskfile byte with its current and previous (older) contents
module taskfile_pair (
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire       wr,
  input  wire [7:0] wdata,
  output reg  [7:0] cur,
  output reg  [7:0] prev
);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cur  <= 8'h00;
      prev <= 8'h00;
    end else if (wr) begin
      prev <= cur;
      cur  <= wdata;
    end
  end

endmodule // taskfile_pair

`default_nettype wire

// [verification/ata_ext_write_cmd_decode_props.sv]
`default_nettype none
module ata_ext_write_cmd_decode_props (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        host_wvalid,
  input wire logic [15:0] host_wdata,
  input wire logic        host_wready,
  input wire logic        media_wvalid,
  input wire logic [15:0] media_wdata,
  input wire logic        media_wready,
  input wire logic        cct_expired,
  input wire logic        busy,
  input wire logic        dma_mode,
  input wire logic        urgent,
  input wire logic        flush_req,
  input wire logic        flush_done,
  input wire logic        cmd_done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_beat; host_wvalid && host_wready; endsequence
  sequence s_fend; flush_req && flush_done; endsequence
  sequence s_done; !flush_req && !busy && cmd_done; endsequence
  property p_word;
    s_beat |=> media_wvalid && media_wdata == $past(host_wdata);
  endproperty
  a_word: assert property (p_word) else $error("word lost");
  property p_hold;
    media_wvalid && !media_wready |=> media_wvalid && $stable(media_wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped");
  property p_idle; !busy |-> !host_wready; endproperty
  a_idle: assert property (p_idle) else $error("ready idle");
  property p_dma; dma_mode |-> busy; endproperty
  a_dma: assert property (p_dma) else $error("dma idle");
  property p_urg; urgent |-> dma_mode; endproperty
  a_urg: assert property (p_urg) else $error("urgent");
  property p_flush; s_fend |=> s_done; endproperty
  a_flush: assert property (p_flush) else $error("flush end");
  property p_fwait;
    flush_req && !flush_done && !cct_expired |=> flush_req && !cmd_done;
  endproperty
  a_fwait: assert property (p_fwait) else $error("flush early");
  property p_ccto; dma_mode && cct_expired |=> s_done; endproperty
  a_ccto: assert property (p_ccto) else $error("time limit");
endmodule // ata_ext_write_cmd_decode_props

bind ata_ext_write_cmd_decode ata_ext_write_cmd_decode_props u_props (
  .clk_sys, .rstn, .host_wvalid, .host_wdata, .host_wready, .media_wvalid,
  .media_wdata, .media_wready, .cct_expired, .busy, .dma_mode, .urgent,
  .flush_req, .flush_done, .cmd_done);
`default_nettype wire

// [verification/ata_ext_write_cmd_decode_tb_top.sv]
`include "ata_ext_write_map.vh"
`default_nettype none
module ata_ext_write_cmd_decode_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WPS = 2;
  logic        clk_sys, rstn, tf_wr, hob, host_wvalid, host_wready, busy;
  logic        media_wvalid, media_wready, err_crc, err_abort, cct_expired;
  logic        dma_mode, urgent, resume_stream_err, flush_req, flush_done;
  logic        cmd_done, log_icrc, log_ccto, stall;
  logic        err_idnf, log_idnf, log_abrt;
  logic [2:0]  tf_addr, tf_rd_addr, stream_id;
  logic [7:0]  tf_wdata, tf_rdata;
  logic [15:0] host_wdata, media_wdata;
  logic [47:0] start_lba;
  logic [15:0] q[$];
  int          errors, n_compared, n_done, n_exp;

  ata_ext_write_cmd_decode #(.WPS(WPS)) u_ata_ext_write_cmd_decode (
    .clk_sys, .rstn, .tf_wr, .tf_addr, .tf_wdata, .tf_rd_addr, .tf_rdata,
    .hob, .host_wvalid, .host_wdata, .host_wready, .media_wvalid,
    .media_wdata, .media_wready, .err_crc, .err_idnf, .err_abort,
    .cct_expired, .busy, .dma_mode, .urgent, .resume_stream_err,
    .stream_id, .start_lba, .flush_req, .flush_done, .cmd_done, .log_icrc,
    .log_idnf, .log_abrt, .log_ccto);
  host_ctrl_model u_host_ctrl_model (.clk_sys, .busy, .host_wready, .tf_wr,
    .tf_addr, .tf_wdata, .host_wvalid, .host_wdata);

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (media_wvalid && media_wready) q.push_back(media_wdata);
    if (cmd_done) n_done++;
  end
  always @(posedge clk_sys) begin
    #1;
    media_wready = !stall || !media_wready;
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic timeout_hit;
    errors++;
    end_sim();
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    tf_rd_addr = a;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(48'(tf_rdata), 48'(exp));
  endtask
  task automatic wait_done;
    int k;
    n_exp++;
    for (k = 0; k < 300 && n_done != n_exp; k++) @(posedge clk_sys) #1;
    if (n_done != n_exp) timeout_hit();
    // Let the last media word drain before anyone looks at the queue
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk_sys) #1;
    s = 1'b1;
    @(posedge clk_sys) #1;
    s = 1'b0;
  endtask
  task automatic setup(input logic [7:0] f, input logic [15:0] c,
                       input logic [47:0] l, input logic [7:0] cmd);
    logic [63:0] v;
    int k;
    v = {c, l[31:24], l[7:0], l[39:32], l[15:8], l[47:40], l[23:16]};
    q.delete();
    u_host_ctrl_model.wr(`TF_FEATURE, 8'h00);
    u_host_ctrl_model.wr(`TF_FEATURE, f);
    for (k = 0; k < 8; k++)
      u_host_ctrl_model.wr(3'(2 + k / 2), v[63 - 8 * k -: 8]);
    u_host_ctrl_model.wr(`TF_COMMAND, cmd);
  endtask

  task automatic t_ext;
    int i;
    stall = 1'b1;
    setup(8'h00, 16'h0002, 48'h1234_5678_9abc, `CMD_WRITE_EXT);
    chk(start_lba, 48'h1234_5678_9abc);
    rd(`TF_STATUS, 8'hc8);
    u_host_ctrl_model.send(2 * WPS, 16'h1000, 1'b1);
    wait_done();
    chk(48'(q.size()), 48'(2 * WPS));
    for (i = 0; i < q.size(); i++) chk(48'(q[i]), 48'(16'h1000 + i));
    rd(`TF_STATUS, 8'h40);
    stall = 1'b0;
    $display("extended write test finished");
  endtask
  task automatic t_abort;
    logic [47:0] f;
    int k;
    f = 48'h0a0b_0c0d_0e10;
    setup(8'h00, 16'h0003, 48'h0a0b_0c0d_0e0f, `CMD_WRITE_EXT);
    u_host_ctrl_model.send(3, 16'h2000, 1'b0);
    pulse(err_abort);
    wait_done();
    u_host_ctrl_model.send(1, 16'h2003, 1'b0);
    chk(48'(q.size()), 48'h3);
    rd(`TF_STATUS, 8'h41);
    rd(`TF_ERROR, 8'h04);
    for (k = 0; k < 6; k++) begin
      hob = (k > 2);
      rd(3'(`TF_SECNUM + k % 3), f[8 * k +: 8]);
    end
    hob = 1'b0;
    $display("abort test finished");
  endtask
  task automatic t_wc;
    setup(8'hc3, 16'h0002, 48'h0000_0000_0100, `CMD_WRITE_STREAM);
    chk(48'({dma_mode, urgent, stream_id}), 48'h1b);
    rd(`TF_STATUS, 8'hc0);
    u_host_ctrl_model.send(2, 16'h3000, 1'b0);
    pulse(err_crc);
    pulse(err_abort);
    u_host_ctrl_model.send(2, 16'h3002, 1'b1);
    wait_done();
    chk(48'(q.size()), 48'h4);
    chk(48'({log_icrc, log_idnf, log_abrt}), 48'h5);
    rd(`TF_STATUS, 8'h60);
    $display("continuous write test finished");
  endtask
  task automatic t_cct;
    setup(8'h40, 16'h0002, 48'h0000_0000_0200, `CMD_WRITE_STREAM);
    u_host_ctrl_model.send(1, 16'h4000, 1'b0);
    pulse(err_idnf);
    pulse(cct_expired);
    wait_done();
    chk(48'({log_ccto, log_idnf, busy}), 48'h6);
    rd(`TF_STATUS, 8'h60);
    $display("time limit test finished");
  endtask
  task automatic t_flush;
    setup(8'h31, 16'h0001, 48'h0000_0000_0300, `CMD_WRITE_STREAM);
    chk(48'({resume_stream_err, stream_id}), 48'h9);
    u_host_ctrl_model.send(WPS, 16'h5000, 1'b0);
    repeat (4) @(posedge clk_sys) #1;
    chk(48'({flush_req, n_done == n_exp}), 48'h3);
    pulse(flush_done);
    wait_done();
    chk(48'(flush_req), 48'h0);
    $display("flush test finished");
  endtask
  task automatic t_misc;
    setup(8'h00, 16'h0000, 48'h0000_0000_0400, `CMD_WRITE_EXT);
    u_host_ctrl_model.send(6, 16'h7000, 1'b0);
    chk(48'(busy), 48'h1);
    pulse(err_crc);
    wait_done();
    rd(`TF_ERROR, 8'h04);
    rd(`TF_SECNUM, 8'h03);
    setup(8'h02, 16'h0001, 48'h0000_0000_0500, `CMD_WRITE_STREAM);
    pulse(cct_expired);
    wait_done();
    rd(`TF_ERROR, 8'h01);
    rd(`TF_STATUS, 8'h41);
    setup(8'h60, 16'h0001, 48'h0000_0000_0600, `CMD_WRITE_STREAM);
    u_host_ctrl_model.send(WPS, 16'h7100, 1'b0);
    repeat (2) @(posedge clk_sys) #1;
    pulse(cct_expired);
    wait_done();
    chk(48'({log_ccto, flush_req, busy}), 48'h4);
    rd(`TF_STATUS, 8'h60);
    setup(8'h00, 16'h0001, 48'h0000_0000_0000, 8'h20);
    wait_done();
    rd(`TF_STATUS, 8'h41);
    u_host_ctrl_model.wr(`TF_DEVICE, 8'h40);
    rd(`TF_DEVICE, 8'h40);
    $display("error path test finished");
  endtask
  task automatic t_reset;
    setup(8'h00, 16'h0001, 48'h0000_0000_0077, `CMD_WRITE_EXT);
    u_host_ctrl_model.send(1, 16'h6000, 1'b0);
    @(posedge clk_sys) #1;
    rstn = 1'b0;
    repeat (2) @(posedge clk_sys) #1;
    rstn = 1'b1;
    chk(48'({busy, host_wready, cmd_done}), 48'h0);
    rd(`TF_STATUS, 8'h40);
    rd(`TF_DEVICE, 8'h00);
    rd(`TF_SECNUM, 8'h00);
    $display("reset test finished");
  endtask

  initial begin
    {rstn, stall, hob, media_wready, err_crc, err_abort, err_idnf} = 7'h00;
    {cct_expired, flush_done, tf_rd_addr} = 5'h00;
    {errors, n_compared, n_done, n_exp} = '0;
    repeat (8) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    rd(`TF_STATUS, 8'h40);
    rd(`TF_ERROR, `ERROR_RESET);
    rd(3'h0, 8'h00);
    t_ext();
    t_abort();
    t_wc();
    t_cct();
    t_flush();
    t_misc();
    t_reset();
    end_sim();
  end
endmodule // ata_ext_write_cmd_decode_tb_top
`default_nettype wire

// [verification/host_ctrl_model.sv]
`default_nettype none
module host_ctrl_model (
  input  wire logic        clk_sys,
  input  wire logic        busy,
  input  wire logic        host_wready,
  output var  logic        tf_wr,
  output var  logic [2:0]  tf_addr,
  output var  logic [7:0]  tf_wdata,
  output var  logic        host_wvalid,
  output var  logic [15:0] host_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tf_wr = 1'b0;
    tf_addr = 3'h0;
    tf_wdata = 8'h00;
    host_wvalid = 1'b0;
    host_wdata = 16'h0000;
  end
  // One strobe per byte, earlier byte of a pair first
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1;
    tf_wr = 1'b1;
    tf_addr = a;
    tf_wdata = d;
    @(posedge clk_sys) #1;
    tf_wr = 1'b0;
    tf_wdata = ~d;
  endtask
  // Offers n words, held until taken; gives up when the command ends
  task automatic send(input int n, input logic [15:0] b, input bit slow);
    int i, k;
    for (i = 0; i < n; i++) begin
      @(posedge clk_sys) #1;
      host_wvalid = 1'b1;
      host_wdata = b + 16'(i);
      k = 0;
      do begin
        @(posedge clk_sys);
        k++;
      end while (!host_wready && busy && k < 200);
      #1;
      host_wvalid = 1'b0;
      host_wdata = ~host_wdata;
      if (k == 200) ata_ext_write_cmd_decode_tb_top.timeout_hit();
      if (!busy) return;
      if (slow) repeat (2) @(posedge clk_sys);
    end
  endtask
endmodule // host_ctrl_model
`default_nettype wire
